// file: nsrcfg_regs.sv
`timescale 1ns/1ps

// What this block does
// - Divider sync enable gates sync pulse to divider.
// - Both sync bits set gives continuous resync.
// - Master sync enable required for any sync.
// - Override bit picks pin or register enable.
// - Local writes reach only selected channels.
// - Bandwidth code 000 selects narrow mode.
// - Bandwidth code 001 selects wide mode.
// - Register control: enable bit turns requantizer on.
// - Enable bit ignored while override bit cleared.
// - Six-bit tuning word, reset value 0x1C.
// - Valid tuning words: 57 narrow, 34 wide.
// - Each tuning step moves band half percent.
module nsrcfg_regs
  import nsrcfg_pkg::*;
#(
  parameter int NUM_CH = 2
)
(
  // Clock, reset and enable.
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic i_ce,
  // Register access from the serial port front end.
  input wire nsrcfg_req_t i_req,
  input wire logic [NUM_CH-1:0] i_chan_sel,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  // Self-test signature, one per channel.
  input wire logic [NUM_CH*16-1:0] i_signature,
  // External pins.
  input wire logic i_sync_pin,
  input wire logic [NUM_CH-1:0] i_mode_pin,
  // Outputs to the datapath and clock divider.
  output logic o_div_sync,
  output logic o_sync_powered,
  output nsrcfg_chan_t [NUM_CH-1:0] o_chan
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (NUM_CH < 1 || NUM_CH > 8)
  begin : g_bad_ch
    $error("NUM_CH must be between 1 and 8.");
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic sync_m_q, sync_m_d, sync_s_q, sync_s_d, sync_p_q, sync_p_d;
  logic [NUM_CH-1:0] mode_m_q, mode_m_d, mode_s_q, mode_s_d;

  // Second stage is the only reader of the first stage.
  always_comb
  begin
    sync_m_d = i_sync_pin;
    sync_s_d = sync_m_q;
    sync_p_d = sync_s_q;
    mode_m_d = i_mode_pin;
    mode_s_d = mode_m_q;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      sync_m_q <= 1'b0;
      sync_s_q <= 1'b0;
      sync_p_q <= 1'b0;
      mode_m_q <= '0;
      mode_s_q <= '0;
    end
    else if (i_ce)
    begin
      sync_m_q <= sync_m_d;
      sync_s_q <= sync_s_d;
      sync_p_q <= sync_p_d;
      mode_m_q <= mode_m_d;
      mode_s_q <= mode_s_d;
    end
  end

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [7:0] sync_ctrl_q, sync_ctrl_d;
  logic [NUM_CH-1:0][7:0] nsr_ctrl_q, nsr_ctrl_d;
  logic [NUM_CH-1:0][5:0] nsr_tune_q, nsr_tune_d;

  // Writes; signature addresses have no write path at all.
  always_comb
  begin
    sync_ctrl_d = sync_ctrl_q;
    nsr_ctrl_d = nsr_ctrl_q;
    nsr_tune_d = nsr_tune_q;
    if (i_req.wr)
    begin
      if (i_req.addr == NSRCFG_ADDR_SYNC_CTRL)
      begin
        sync_ctrl_d = {6'h00, i_req.wdata[NSRCFG_BIT_DIV_SYNC:0]};
      end
      for (int c = 0; c < NUM_CH; c++)
      begin
        if (i_chan_sel[c])
        begin
          if (i_req.addr == NSRCFG_ADDR_NSR_CTRL)
          begin
            nsr_ctrl_d[c] = {3'h0, i_req.wdata[NSRCFG_BIT_PIN_OVERRIDE:0]};
          end
          if (i_req.addr == NSRCFG_ADDR_NSR_TUNE)
          begin
            nsr_tune_d[c] = i_req.wdata[5:0];
          end
        end
      end
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      sync_ctrl_q <= NSRCFG_RST_SYNC_CTRL;
      for (int c = 0; c < NUM_CH; c++)
      begin
        nsr_ctrl_q[c] <= NSRCFG_RST_NSR_CTRL;
        nsr_tune_q[c] <= NSRCFG_RST_NSR_TUNE;
      end
    end
    else if (i_ce)
    begin
      sync_ctrl_q <= sync_ctrl_d;
      nsr_ctrl_q <= nsr_ctrl_d;
      nsr_tune_q <= nsr_tune_d;
    end
  end

  // ----------------------------------------------------------------
  // Read-back
  // ----------------------------------------------------------------
  logic [7:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic [2:0] rd_ch;

  // Local reads return the lowest selected channel.
  always_comb
  begin
    rd_ch = '0;
    for (int c = NUM_CH - 1; c >= 0; c--)
    begin
      if (i_chan_sel[c])
      begin
        rd_ch = c[2:0];
      end
    end
    rvalid_d = i_req.rd;
    rdata_d = rdata_q;
    if (i_req.rd)
    begin
      case (i_req.addr)
        NSRCFG_ADDR_SIG_LOW: rdata_d = i_signature[rd_ch*16 +: 8];
        NSRCFG_ADDR_SIG_HIGH: rdata_d = i_signature[rd_ch*16+8 +: 8];
        NSRCFG_ADDR_SYNC_CTRL: rdata_d = sync_ctrl_q;
        NSRCFG_ADDR_NSR_CTRL: rdata_d = nsr_ctrl_q[rd_ch];
        NSRCFG_ADDR_NSR_TUNE: rdata_d = {2'h0, nsr_tune_q[rd_ch]};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end
    else if (i_ce)
    begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign o_rdata = rdata_q;
  assign o_rvalid = rvalid_q;

  // ----------------------------------------------------------------
  // Sync gating
  // ----------------------------------------------------------------
  logic div_sync_q, div_sync_d, sync_pwr_q, sync_pwr_d;

  // Rising sync edge passes only with both enables set, every time.
  always_comb
  begin
    sync_pwr_d = sync_ctrl_q[NSRCFG_BIT_MASTER_SYNC];
    div_sync_d = sync_s_q && !sync_p_q
                 && sync_ctrl_q[NSRCFG_BIT_MASTER_SYNC]
                 && sync_ctrl_q[NSRCFG_BIT_DIV_SYNC];
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      div_sync_q <= 1'b0;
      sync_pwr_q <= 1'b0;
    end
    else if (i_ce)
    begin
      div_sync_q <= div_sync_d;
      sync_pwr_q <= sync_pwr_d;
    end
  end

  assign o_div_sync = div_sync_q;
  assign o_sync_powered = sync_pwr_q;

  // ----------------------------------------------------------------
  // Requantizer channel controls
  // ----------------------------------------------------------------
  nsrcfg_chan_t [NUM_CH-1:0] chan_q, chan_d;

  always_comb
  begin
    for (int c = 0; c < NUM_CH; c++)
    begin
      logic [2:0] bw;
      bw = nsr_ctrl_q[c][NSRCFG_BW_MSB:NSRCFG_BW_LSB];
      // Pin decides unless override set; enable bit ignored otherwise.
      chan_d[c].active = nsr_ctrl_q[c][NSRCFG_BIT_PIN_OVERRIDE]
                         ? nsr_ctrl_q[c][NSRCFG_BIT_NSR_ENABLE]
                         : mode_s_q[c];
      chan_d[c].narrow = (bw == NSRCFG_BW_NARROW);
      chan_d[c].wide = (bw == NSRCFG_BW_WIDE);
      // Tuning word counts half-percent steps of the sample rate.
      chan_d[c].tune = nsr_tune_q[c];
      chan_d[c].tune_valid = ((bw == NSRCFG_BW_NARROW) && (nsr_tune_q[c] < NSRCFG_TUNE_COUNT_NARROW))
                             || ((bw == NSRCFG_BW_WIDE) && (nsr_tune_q[c] < NSRCFG_TUNE_COUNT_WIDE));
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      chan_q <= '0;
    end
    else if (i_ce)
    begin
      chan_q <= chan_d;
    end
  end

  assign o_chan = chan_q;

endmodule : nsrcfg_regs

// file: nsrcfg_pkg.sv
package nsrcfg_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] NSRCFG_ADDR_SIG_LOW = 8'h24;
  localparam logic [7:0] NSRCFG_ADDR_SIG_HIGH = 8'h25;
  localparam logic [7:0] NSRCFG_ADDR_SYNC_CTRL = 8'h3a;
  localparam logic [7:0] NSRCFG_ADDR_NSR_CTRL = 8'h3c;
  localparam logic [7:0] NSRCFG_ADDR_NSR_TUNE = 8'h3e;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] NSRCFG_RST_SYNC_CTRL = 8'h00;
  localparam logic [7:0] NSRCFG_RST_NSR_CTRL = 8'h00;
  localparam logic [5:0] NSRCFG_RST_NSR_TUNE = 6'h1c;

  // ----------------------------------------------------------------
  // Field positions and codes
  // ----------------------------------------------------------------
  localparam int NSRCFG_BIT_MASTER_SYNC = 0;
  localparam int NSRCFG_BIT_DIV_SYNC = 1;
  localparam int NSRCFG_BIT_NSR_ENABLE = 0;
  localparam int NSRCFG_BIT_PIN_OVERRIDE = 4;
  localparam int NSRCFG_BW_LSB = 1;
  localparam int NSRCFG_BW_MSB = 3;
  localparam logic [2:0] NSRCFG_BW_NARROW = 3'h0;
  localparam logic [2:0] NSRCFG_BW_WIDE = 3'h1;
  localparam logic [5:0] NSRCFG_TUNE_COUNT_NARROW = 6'h39;
  localparam logic [5:0] NSRCFG_TUNE_COUNT_WIDE = 6'h22;

  // Register write/read request from the serial port front end.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } nsrcfg_req_t;

  // Per-channel requantizer settings.
  typedef struct packed {
    logic       active;
    logic       narrow;
    logic       wide;
    logic       tune_valid;
    logic [5:0] tune;
  } nsrcfg_chan_t;

endpackage : nsrcfg_pkg

// file: nsrcfg_regs_sva.sv
`timescale 1ns/1ps
// ----------
// Checker
// ----------
module nsrcfg_regs_sva
  import nsrcfg_pkg::*;
#(
  parameter int NUM_CH = 2
)
(
  // Clock, reset and inputs.
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire nsrcfg_req_t i_req,
  input wire logic [NUM_CH-1:0] i_chan_sel,
  input wire logic [NUM_CH*16-1:0] i_signature,
  input wire logic i_sync_pin,
  // Outputs.
  input wire logic [7:0] o_rdata,
  input wire logic o_rvalid,
  input wire logic o_div_sync,
  input wire logic o_sync_powered,
  input wire nsrcfg_chan_t [NUM_CH-1:0] o_chan
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);
  // Writes that land on channel 0.
  wire logic wr0 = i_ce && i_req.wr && i_chan_sel[0];
  wire logic wr_ctl0 = wr0 && i_req.addr == NSRCFG_ADDR_NSR_CTRL;
  // Reads answer one cycle later and the signature is passed through.
  rd_answer_a:
    assert property (i_ce && i_req.rd |=> o_rvalid) else $error("Read not answered.");
  rd_cause_a:
    assert property (o_rvalid |-> $past(i_req.rd)) else $error("Answer without read.");
  sig_read_a:
    assert property (o_rvalid && $past(i_req.addr) == NSRCFG_ADDR_SIG_LOW && $past(i_chan_sel[0])
      |-> o_rdata == $past(i_signature[7:0])) else $error("Signature byte wrong.");
  // Divider pulses follow a pin rise by three edges and need master sync.
  sync_time_a:
    assert property (o_div_sync |-> $past(i_sync_pin, 3) && !$past(i_sync_pin, 4)) else $error("Pulse timing.");
  sync_gate_a:
    assert property (o_div_sync |-> o_sync_powered) else $error("Pulse while unpowered.");
  // Channel settings follow register writes two cycles later.
  reg_enable_a:
    assert property (wr_ctl0 && i_req.wdata[4] |-> ##2 o_chan[0].active == $past(i_req.wdata[0], 2))
      else $error("Enable not applied.");
  bw_mode_a:
    assert property (wr_ctl0 |-> ##2 o_chan[0].narrow == ($past(i_req.wdata[3:1], 2) == 3'h0)
      && o_chan[0].wide == ($past(i_req.wdata[3:1], 2) == 3'h1)) else $error("Mode wrong.");
  tune_word_a:
    assert property (wr0 && i_req.addr == NSRCFG_ADDR_NSR_TUNE |-> ##2 o_chan[0].tune == $past(i_req.wdata[5:0], 2))
      else $error("Tune not applied.");
  unsel_keep_a:
    assert property (i_ce && i_req.wr && !i_chan_sel[1] |-> ##2 $stable(o_chan[1].tune)) else $error("Unselected changed.");
  tune_valid_a:
    assert property (o_chan[0].tune_valid == (o_chan[0].narrow && o_chan[0].tune < NSRCFG_TUNE_COUNT_NARROW
      || o_chan[0].wide && o_chan[0].tune < NSRCFG_TUNE_COUNT_WIDE)) else $error("Tune valid wrong.");
  // Main scenarios reached.
  cover property (o_div_sync);
  cover property (wr_ctl0 && i_req.wdata[4]);
  cover property (o_rvalid && o_rdata != 8'h00);
endmodule : nsrcfg_regs_sva

// file: nsrcfg_host.sv
`timescale 1ns/1ps
// ----------
// Host model
// ----------
module nsrcfg_host
  import nsrcfg_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic [7:0] i_rdata,
  input wire logic i_rvalid,
  output nsrcfg_req_t o_req
);
  // The port stays quiet unless a task is called.
  initial o_req = '0;
  // One-cycle write pulse; callers leave master sync low when unused.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    o_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_clk_sys);
    o_req <= '0;
  endtask : wr
  // One-cycle read pulse, then a bounded wait for the answer.
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    ok = 1'b0;
    @(posedge i_clk_sys);
    o_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge i_clk_sys);
    o_req <= '0;
    for (int i = 0; i < 4 && !ok; i++)
    begin
      @(posedge i_clk_sys);
      ok = i_rvalid;
      d = i_rdata;
    end
  endtask : rd
endmodule : nsrcfg_host

// file: nsrcfg_regs_tb_top.sv
`timescale 1ns/1ps
module nsrcfg_regs_tb_top;
  import nsrcfg_pkg::*;
  // ----------
  // Signals
  // ----------
  logic clk = 1'b0, srst = 1'b1, ce = 1'b1, sync_pin = 1'b0, ok, n, w, rvalid, div_sync, sync_pw;
  logic [1:0] mode_pin = 2'h0, sel = 2'h1;
  logic [31:0] sig = 32'hb7a5c3d1;
  logic [7:0] rdata, d;
  logic [7:0] ctl [5] = '{8'h12, 8'h12, 8'h10, 8'h10, 8'h14};
  logic [5:0] tw [5] = '{6'h21, 6'h22, 6'h38, 6'h39, 6'h00};
  nsrcfg_req_t req;
  nsrcfg_chan_t [1:0] chan;
  int checks = 0, miscompares = 0, npulse = 0;
  // Clock and divider pulse counter.
  always #5 clk = ~clk;
  always @(posedge clk) if (div_sync) npulse <= npulse + 1;
  nsrcfg_regs #(.NUM_CH(2)) DUT (.i_clk_sys(clk), .i_srst(srst), .i_ce(ce), .i_req(req), .i_chan_sel(sel),
    .o_rdata(rdata), .o_rvalid(rvalid), .i_signature(sig), .i_sync_pin(sync_pin), .i_mode_pin(mode_pin),
    .o_div_sync(div_sync), .o_sync_powered(sync_pw), .o_chan(chan));
  nsrcfg_host host (.i_clk_sys(clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_req(req));
  // Closing report.
  task automatic give_verdict;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict
  // Compare tasks for register bytes and channel settings.
  task automatic chk_r(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask : chk_r
  task automatic chk_c(input nsrcfg_chan_t got, input nsrcfg_chan_t exp);
    checks++;
    if (got !== exp)
    begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask : chk_c
  // Read a register and compare; a lost answer ends the run.
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, d, ok);
    if (!ok)
    begin
      miscompares++;
      give_verdict();
    end
    chk_r(d, exp);
  endtask : rchk
  task automatic settle(input int n_cyc);
    repeat (n_cyc) @(posedge clk);
    #1;
  endtask : settle
  // Watchdog against a hang.
  initial
  begin
    repeat (5000) @(posedge clk);
    miscompares++;
    give_verdict();
  end
  // Main sequence.
  initial
  begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    settle(2);
    rchk(NSRCFG_ADDR_SYNC_CTRL, 8'h00);
    rchk(NSRCFG_ADDR_NSR_CTRL, 8'h00);
    rchk(NSRCFG_ADDR_NSR_TUNE, 8'h1c);
    chk_c(chan[1], {1'b0, 1'b1, 1'b0, 1'b1, 6'h1c});
    host.wr(NSRCFG_ADDR_SIG_LOW, 8'h55);
    rchk(NSRCFG_ADDR_SIG_LOW, 8'hd1);
    @(posedge clk) sel <= 2'h2;
    rchk(NSRCFG_ADDR_SIG_HIGH, 8'hb7);
    rchk(8'h30, 8'h00);
    @(posedge clk) sel <= 2'h1;
    $display("Test signature done");
    host.wr(NSRCFG_ADDR_NSR_CTRL, 8'hf1);
    rchk(NSRCFG_ADDR_NSR_CTRL, 8'h11);
    chk_c(chan[0], {1'b1, 1'b1, 1'b0, 1'b1, 6'h1c});
    chk_c(chan[1], {1'b0, 1'b1, 1'b0, 1'b1, 6'h1c});
    host.wr(NSRCFG_ADDR_NSR_CTRL, 8'h01);
    settle(2);
    chk_c(chan[0], {1'b0, 1'b1, 1'b0, 1'b1, 6'h1c});
    @(posedge clk) mode_pin <= 2'h1;
    settle(6);
    chk_c(chan[0], {1'b1, 1'b1, 1'b0, 1'b1, 6'h1c});
    $display("Test enable source done");
    for (int i = 0; i < 5; i++)
    begin
      host.wr(NSRCFG_ADDR_NSR_CTRL, ctl[i]);
      host.wr(NSRCFG_ADDR_NSR_TUNE, {2'h0, tw[i]});
      settle(2);
      n = ctl[i][3:1] == 3'h0;
      w = ctl[i][3:1] == 3'h1;
      chk_c(chan[0], {1'b0, n, w, (n && tw[i] < 6'h39) || (w && tw[i] < 6'h22), tw[i]});
    end
    $display("Test bandwidth done");
    // A write while the clock enable is low must leave the tuning word alone.
    @(posedge clk) ce <= 1'b0;
    host.wr(NSRCFG_ADDR_NSR_TUNE, 8'h2a);
    @(posedge clk) ce <= 1'b1;
    rchk(NSRCFG_ADDR_NSR_TUNE, 8'h00);
    $display("Test clock enable done");
    for (int m = 0; m < 4; m++)
    begin
      host.wr(NSRCFG_ADDR_SYNC_CTRL, {6'h00, m[1:0]});
      settle(2);
      npulse = 0;
      repeat (2)
      begin
        @(posedge clk) sync_pin <= 1'b1;
        settle(3);
        @(posedge clk) sync_pin <= 1'b0;
        settle(3);
      end
      settle(6);
      chk_r(8'(npulse), (m == 3) ? 8'h02 : 8'h00);
      chk_r({7'h00, sync_pw}, {7'h00, m[0]});
      rchk(NSRCFG_ADDR_SYNC_CTRL, {6'h00, m[1:0]});
    end
    host.wr(NSRCFG_ADDR_SYNC_CTRL, 8'h00);
    $display("Test sync done");
    give_verdict();
  end
endmodule : nsrcfg_regs_tb_top

bind nsrcfg_regs nsrcfg_regs_sva #(.NUM_CH(NUM_CH)) u_sva (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_ce(i_ce),
  .i_req(i_req), .i_chan_sel(i_chan_sel), .i_signature(i_signature), .i_sync_pin(i_sync_pin), .o_rdata(o_rdata),
  .o_rvalid(o_rvalid), .o_div_sync(o_div_sync), .o_sync_powered(o_sync_powered), .o_chan(o_chan));
